// ### src/rocof_stages.sv
// Eight-stage frequency slope protection with events and counters
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "rocof_params.svh"

module rocof_stages
    import rocof_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `ROCOF_MS_CYC
) (
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic [11:0] reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    input  wire logic [15:0] freq_i,
    input  wire logic [15:0] slope_i,
    input  wire logic        meas_valid_i,
    input  wire logic [7:0]  block_i,
    input  wire logic [2:0]  sg_sel_i,
    output logic      [1:0]  freq_ref_sel_o,
    output logic      [7:0]  start_o,
    output logic      [7:0]  trip_o,
    output logic      [7:0]  blocked_o,
    output logic             evt_valid_o,
    output logic      [2:0]  evt_stage_o,
    output logic      [1:0]  evt_kind_o,
    output logic             evt_on_o,
    output logic      [31:0] evt_time_o
);

    // ************************************************
    // Global control registers
    // ************************************************
    logic [1:0]  ref_q,  ref_d;
    logic        frc_q,  frc_d;
    logic        clr_q,  clr_d;
    logic [15:0] maxr_q, maxr_d;
    logic [15:0] sten_q, sten_d;
    logic [15:0] fcod_q, fcod_d;

    // Control register writes; clear request lasts one cycle
    always_comb begin
        ref_d  = ref_q;
        frc_d  = frc_q;
        clr_d  = 1'b0;
        maxr_d = maxr_q;
        sten_d = sten_q;
        fcod_d = fcod_q;
        if (reg_wr_i) begin
            if (reg_addr_i == `ROCOF_CTRL) begin
                // Code 3 names no reference, so it is refused
                if (reg_wdata_i[`ROCOF_CTRL_REF +: 2] != 2'h3) begin
                    ref_d = reg_wdata_i[`ROCOF_CTRL_REF +: 2];
                end
                frc_d = reg_wdata_i[`ROCOF_CTRL_FORCE];
                clr_d = reg_wdata_i[`ROCOF_CTRL_CLR];
            end else if (reg_addr_i == `ROCOF_MAXRATE) begin
                maxr_d = reg_wdata_i[15:0];
            end else if (reg_addr_i == `ROCOF_STEN) begin
                sten_d = reg_wdata_i[15:0];
            end else if (reg_addr_i == `ROCOF_FORCE) begin
                fcod_d = reg_wdata_i[15:0];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref_q  <= 2'h0;
            frc_q  <= 1'b0;
            clr_q  <= 1'b0;
            maxr_q <= `ROCOF_MAXRATE_RST;
            sten_q <= `ROCOF_STEN_RST;
            fcod_q <= 16'h0000;
        end else begin
            ref_q  <= ref_d;
            frc_q  <= frc_d;
            clr_q  <= clr_d;
            maxr_q <= maxr_d;
            sten_q <= sten_d;
            fcod_q <= fcod_d;
        end
    end

    // ************************************************
    // Setting groups: 8 groups x 8 stages
    // ************************************************
    logic [3:0]  cfg_q  [64];
    logic [3:0]  cfg_d  [64];
    logic [15:0] pick_q [64];
    logic [15:0] pick_d [64];
    logic [15:0] fuf_q  [64];
    logic [15:0] fuf_d  [64];
    logic [15:0] fof_q  [64];
    logic [15:0] fof_d  [64];
    logic [18:0] dly_q  [64];
    logic [18:0] dly_d  [64];
    logic [5:0]  widx;

    // Address bits select group, stage and field
    assign widx = reg_addr_i[10:5];

    always_comb begin
        cfg_d  = cfg_q;
        pick_d = pick_q;
        fuf_d  = fuf_q;
        fof_d  = fof_q;
        dly_d  = dly_q;
        if (reg_wr_i && reg_addr_i[`ROCOF_SET_BIT]) begin
            case (reg_addr_i[4:2])
                `ROCOF_SET_CFG:  cfg_d[widx]  = reg_wdata_i[3:0];
                `ROCOF_SET_PICK: pick_d[widx] = reg_wdata_i[15:0];
                `ROCOF_SET_FUF:  fuf_d[widx]  = reg_wdata_i[15:0];
                `ROCOF_SET_FOF:  fof_d[widx]  = reg_wdata_i[15:0];
                `ROCOF_SET_DLY:  dly_d[widx]  = reg_wdata_i[18:0];
                default: ;
            endcase
        end
    end

    // Defaults: excluded, rising, gates unused
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < 64; i++) begin
                cfg_q[i]  <= `ROCOF_CFG_RST;
                pick_q[i] <= `ROCOF_PICK_RST;
                fuf_q[i]  <= `ROCOF_FUF_RST;
                fof_q[i]  <= `ROCOF_FOF_RST;
                dly_q[i]  <= 19'(`ROCOF_DLY_RST);
            end
        end else begin
            cfg_q  <= cfg_d;
            pick_q <= pick_d;
            fuf_q  <= fuf_d;
            fof_q  <= fof_d;
            dly_q  <= dly_d;
        end
    end

    // ************************************************
    // Time base, processing cycle and measurements
    // ************************************************
    logic [31:0] div_q,  div_d;
    logic [31:0] ms_q,   ms_d;
    logic [2:0]  prc_q,  prc_d;
    logic        tick;
    logic [15:0] freq_q, freq_d;
    logic [15:0] slp_q,  slp_d;
    logic [15:0] mag;
    logic        maxblk;

    // 1 ms stamp counter and 5 ms evaluation strobe
    always_comb begin
        div_d  = div_q + 32'h1;
        ms_d   = ms_q;
        prc_d  = prc_q;
        tick   = 1'b0;
        freq_d = meas_valid_i ? freq_i : freq_q;
        slp_d  = meas_valid_i ? slope_i : slp_q;
        if (div_q == MS_CYCLES - 32'h1) begin
            div_d = 32'h0;
            ms_d  = ms_q + 32'h1;
            prc_d = prc_q + 3'h1;
            if (prc_q == 3'(`ROCOF_PROC_MS - 1)) begin
                prc_d = 3'h0;
                tick  = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_q  <= 32'h0;
            ms_q   <= 32'h0;
            prc_q  <= 3'h0;
            freq_q <= 16'h0000;
            slp_q  <= 16'h0000;
        end else begin
            div_q  <= div_d;
            ms_q   <= ms_d;
            prc_q  <= prc_d;
            freq_q <= freq_d;
            slp_q  <= slp_d;
        end
    end

    // Slope magnitude and global rate block
    assign mag    = slp_q[15] ? 16'(-slp_q) : slp_q;
    assign maxblk = mag > maxr_q;

    // ************************************************
    // Protection stages
    // ************************************************
    logic [7:0]  st_w, tr_w, bl_w;
    logic [23:0] chg_w, lvl_w;
    logic [15:0] cnt_w   [8][3];
    logic [15:0] ratio_w [8];

    for (genvar s = 0; s < 8; s++) begin : g_stage
        logic        pk_q, pk_d, st_q, st_d;
        logic        tr_q, tr_d, bl_q, bl_d;
        logic [18:0] tm_q, tm_d;
        logic [15:0] rt_q, rt_d;
        logic [15:0] cn_q [3];
        logic [15:0] cn_d [3];
        logic [5:0]  ai;
        logic [3:0]  cf;
        logic [15:0] pk, hold;
        logic        on, rise, fall, dok, gok, blk;
        logic [31:0] quo;
        rocof_dir_t   dir;
        rocof_force_t fc;

        // Active group picks this stage's settings
        assign ai = {sg_sel_i, 3'(s)};

        always_comb begin
            cf   = cfg_q[ai];
            pk   = pick_q[ai];
            dir  = rocof_dir_t'(cf[2:1]);
            fc   = rocof_force_t'(fcod_q[2*s +: 2]);
            on   = (sten_q[2*s +: 2] == `ROCOF_EN_YES)
                   && cf[0];
            rise = !slp_q[15] && (slp_q != 16'h0000);
            fall = slp_q[15];
            dok  = (dir == ROCOF_DIR_RISE && rise)
                || (dir == ROCOF_DIR_FALL && fall)
                || (dir == ROCOF_DIR_BOTH
                    && (rise || fall));
            gok  = !cf[3]
                || (fall && dir != ROCOF_DIR_RISE
                    && freq_q < fuf_q[ai])
                || (rise && dir != ROCOF_DIR_FALL
                    && freq_q > fof_q[ai]);
            hold = (pk > `ROCOF_HYST) ? pk - `ROCOF_HYST
                                      : 16'h0000;
            blk  = block_i[s] || maxblk;
            quo  = (pk == 16'h0000) ? 32'h0
                 : (32'(mag) * `ROCOF_RATIO_ONE) / 32'(pk);
            rt_d = (quo > 32'(`ROCOF_RATIO_MAX))
                 ? `ROCOF_RATIO_MAX : quo[15:0];
            pk_d = pk_q;
            st_d = st_q;
            tr_d = tr_q;
            bl_d = bl_q;
            tm_d = tm_q;
            if (tick) begin
                pk_d = on && dok && gok
                    && (pk_q ? (mag > hold) : (mag >= pk));
                st_d = pk_d && !blk;
                bl_d = pk_d && blk;
                tm_d = (st_d && st_q)
                     ? ((tm_q == 19'h7ffff) ? tm_q : tm_q + 19'h1)
                     : 19'h0;
                tr_d = st_d && (tm_d >= dly_q[ai]);
                if (frc_q) begin
                    st_d = on && (fc == ROCOF_FRC_START
                               || fc == ROCOF_FRC_TRIP);
                    tr_d = on && (fc == ROCOF_FRC_TRIP);
                    bl_d = on && (fc == ROCOF_FRC_BLOCKED);
                    tm_d = 19'h0;
                end
            end
            // Counters bump on each rising output edge
            for (int k = 0; k < 3; k++) begin
                cn_d[k] = clr_q ? 16'h0000 : cn_q[k];
            end
            if (st_d && !st_q) cn_d[0] = cn_d[0] + 16'h1;
            if (tr_d && !tr_q) cn_d[1] = cn_d[1] + 16'h1;
            if (bl_d && !bl_q) cn_d[2] = cn_d[2] + 16'h1;
        end

        always_ff @(posedge mclk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                pk_q <= 1'b0;
                st_q <= 1'b0;
                tr_q <= 1'b0;
                bl_q <= 1'b0;
                tm_q <= 19'h0;
                rt_q <= 16'h0000;
                for (int k = 0; k < 3; k++) begin
                    cn_q[k] <= 16'h0000;
                end
            end else begin
                pk_q <= pk_d;
                st_q <= st_d;
                tr_q <= tr_d;
                bl_q <= bl_d;
                tm_q <= tm_d;
                rt_q <= rt_d;
                cn_q <= cn_d;
            end
        end

        // Stage outputs and event sources
        assign st_w[s]        = st_q;
        assign tr_w[s]        = tr_q;
        assign bl_w[s]        = bl_q;
        assign chg_w[3*s +: 3] = {bl_d ^ bl_q, tr_d ^ tr_q,
                                  st_d ^ st_q};
        assign lvl_w[3*s +: 3] = {bl_d, tr_d, st_d};
        assign ratio_w[s]     = rt_q;
        assign cnt_w[s][0]    = cn_q[0];
        assign cnt_w[s][1]    = cn_q[1];
        assign cnt_w[s][2]    = cn_q[2];
    end

    // ************************************************
    // Event posting, one event per clock
    // ************************************************
    logic [23:0] pnd_q, pnd_d;
    logic [23:0] pon_q, pon_d;
    logic [31:0] ets_q, ets_d;
    logic        ev_q,  ev_d;
    logic [2:0]  es_q,  es_d;
    logic [1:0]  ek_q,  ek_d;
    logic        eo_q,  eo_d;
    logic [31:0] et_q,  et_d;

    // All changes of one cycle share one stamp
    always_comb begin
        pnd_d = pnd_q;
        pon_d = pon_q;
        ets_d = tick ? ms_q : ets_q;
        ev_d  = 1'b0;
        es_d  = es_q;
        ek_d  = ek_q;
        eo_d  = eo_q;
        et_d  = et_q;
        for (int k = 23; k >= 0; k--) begin
            if (pnd_q[k]) begin
                ev_d = 1'b1;
                es_d = 3'(k / 3);
                ek_d = 2'(k % 3);
                eo_d = pon_q[k];
                et_d = ets_q;
            end
        end
        for (int k = 0; k < 24; k++) begin
            if (pnd_q[k] && es_d == 3'(k / 3)
                && ek_d == 2'(k % 3)) begin
                pnd_d[k] = 1'b0;
            end
        end
        // A new change wins over the drain of its bit
        for (int k = 0; k < 24; k++) begin
            if (chg_w[k]) begin
                pnd_d[k] = 1'b1;
                pon_d[k] = lvl_w[k];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pnd_q <= 24'h0;
            pon_q <= 24'h0;
            ets_q <= 32'h0;
            ev_q  <= 1'b0;
            es_q  <= 3'h0;
            ek_q  <= 2'h0;
            eo_q  <= 1'b0;
            et_q  <= 32'h0;
        end else begin
            pnd_q <= pnd_d;
            pon_q <= pon_d;
            ets_q <= ets_d;
            ev_q  <= ev_d;
            es_q  <= es_d;
            ek_q  <= ek_d;
            eo_q  <= eo_d;
            et_q  <= et_d;
        end
    end

    // ************************************************
    // Register read port
    // ************************************************
    logic [31:0] rd_q, rd_d;

    // Data valid only in the cycle after the read strobe
    always_comb begin
        rd_d = 32'h0;
        if (reg_rd_i) begin
            if (reg_addr_i == `ROCOF_CTRL) begin
                rd_d = {28'h0, 1'b0, frc_q, ref_q};
            end else if (reg_addr_i == `ROCOF_MAXRATE) begin
                rd_d = {16'h0, maxr_q};
            end else if (reg_addr_i == `ROCOF_STEN) begin
                rd_d = {16'h0, sten_q};
            end else if (reg_addr_i == `ROCOF_FORCE) begin
                rd_d = {16'h0, fcod_q};
            end else if (reg_addr_i == `ROCOF_STATUS) begin
                rd_d = {8'h0, bl_w, tr_w, st_w};
            end else if (reg_addr_i == `ROCOF_TIME) begin
                rd_d = ms_q;
            end else if (reg_addr_i[11:8] == `ROCOF_CNT_PAGE
                         && reg_addr_i[3:2] != 2'h3) begin
                rd_d = {16'h0,
                        cnt_w[reg_addr_i[6:4]][reg_addr_i[3:2]]};
            end else if (reg_addr_i[11:8] == `ROCOF_RATIO_PAGE) begin
                rd_d = {16'h0, ratio_w[reg_addr_i[4:2]]};
            end else if (reg_addr_i[`ROCOF_SET_BIT]) begin
                case (reg_addr_i[4:2])
                    `ROCOF_SET_CFG:  rd_d = {28'h0, cfg_q[widx]};
                    `ROCOF_SET_PICK: rd_d = {16'h0, pick_q[widx]};
                    `ROCOF_SET_FUF:  rd_d = {16'h0, fuf_q[widx]};
                    `ROCOF_SET_FOF:  rd_d = {16'h0, fof_q[widx]};
                    `ROCOF_SET_DLY:  rd_d = {13'h0, dly_q[widx]};
                    default:         rd_d = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_q <= 32'h0;
        end else begin
            rd_q <= rd_d;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign reg_rdata_o    = rd_q;
    assign freq_ref_sel_o = ref_q;
    assign start_o        = st_w;
    assign trip_o         = tr_w;
    assign blocked_o      = bl_w;
    assign evt_valid_o    = ev_q;
    assign evt_stage_o    = es_q;
    assign evt_kind_o     = ek_q;
    assign evt_on_o       = eo_q;
    assign evt_time_o     = et_q;

endmodule // rocof_stages

// ### common/rocof_params.svh
// Constants for the frequency slope protection stages
`ifndef ROCOF_PARAMS_SVH
`define ROCOF_PARAMS_SVH

// ****************************************************
// Timing
// ****************************************************
`define ROCOF_CLK_HZ      50000000
`define ROCOF_TS_MS       1
`define ROCOF_MS_CYC      (`ROCOF_CLK_HZ / 1000 * `ROCOF_TS_MS)
`define ROCOF_PROC_MS     5
`define ROCOF_DLY_MS      100
`define ROCOF_DLY_RST     (`ROCOF_DLY_MS / `ROCOF_PROC_MS)

// ****************************************************
// Scaling (slope in 0.01 Hz/s, frequency in 0.01 Hz)
// ****************************************************
`define ROCOF_HYST        16'h000a
`define ROCOF_RATIO_ONE   32'h0000_03e8
`define ROCOF_RATIO_MAX   16'h4e20

// ****************************************************
// Register offsets
// ****************************************************
`define ROCOF_CTRL        12'h000
`define ROCOF_MAXRATE     12'h004
`define ROCOF_STEN        12'h008
`define ROCOF_FORCE       12'h00c
`define ROCOF_STATUS      12'h010
`define ROCOF_TIME        12'h014
`define ROCOF_CNT_PAGE    4'h1
`define ROCOF_RATIO_PAGE  4'h2
`define ROCOF_SET_BIT     11

// ****************************************************
// Field positions
// ****************************************************
`define ROCOF_CTRL_REF    0
`define ROCOF_CTRL_FORCE  2
`define ROCOF_CTRL_CLR    3
`define ROCOF_SET_CFG     3'h0
`define ROCOF_SET_PICK    3'h1
`define ROCOF_SET_FUF     3'h2
`define ROCOF_SET_FOF     3'h3
`define ROCOF_SET_DLY     3'h4

// ****************************************************
// Reset values and stage enable code
// ****************************************************
`define ROCOF_MAXRATE_RST 16'h07d0
`define ROCOF_STEN_RST    16'h5555
`define ROCOF_EN_YES      2'h2
`define ROCOF_CFG_RST     4'h0
`define ROCOF_PICK_RST    16'h0014
`define ROCOF_FUF_RST     16'h1383
`define ROCOF_FOF_RST     16'h13ec

`endif

// ### common/rocof_pkg.sv
// Types for the frequency slope protection stages
package rocof_pkg;
    typedef enum logic [1:0] {
        ROCOF_EV_START,
        ROCOF_EV_TRIP,
        ROCOF_EV_BLOCK
    } rocof_evt_t;

    typedef enum logic [1:0] {
        ROCOF_DIR_RISE,
        ROCOF_DIR_FALL,
        ROCOF_DIR_BOTH
    } rocof_dir_t;

    typedef enum logic [1:0] {
        ROCOF_FRC_NORMAL,
        ROCOF_FRC_START,
        ROCOF_FRC_TRIP,
        ROCOF_FRC_BLOCKED
    } rocof_force_t;
endpackage

// ### sim/rocof_stages_checker.sv
// Port assertions for the slope protection stages
`timescale 1ns/1ps
`include "rocof_params.svh"
module rocof_stages_checker #(
    parameter int unsigned MS_CYCLES = 10
) (
    input wire logic        mclk_i,
    input wire logic        reset_n_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [1:0]  freq_ref_sel_o,
    input wire logic [7:0]  start_o,
    input wire logic [7:0]  trip_o,
    input wire logic [7:0]  blocked_o,
    input wire logic        evt_valid_o,
    input wire logic [1:0]  evt_kind_o,
    input wire logic [31:0] evt_time_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // Status read with the stage levels steady across the read slot
    sequence s_status_rd;
        reg_rd_i && reg_addr_i == `ROCOF_STATUS
        ##1 $stable({blocked_o, trip_o, start_o});
    endsequence
    a_rdata_idle: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside its slot");
    a_status_rd: assert property (
        s_status_rd |-> reg_rdata_o == {8'h0, blocked_o, trip_o, start_o})
        else $error("status read mismatch");
    a_start_blk: assert property (
        (start_o & blocked_o) == 8'h0)
        else $error("start and blocked together");
    a_evt_follows: assert property (
        $changed({start_o, trip_o, blocked_o}) |-> ##[0:3] evt_valid_o)
        else $error("level change without event");
    a_outs_hold: assert property (
        $changed({start_o, trip_o, blocked_o})
        |=> $stable({start_o, trip_o, blocked_o})[*8])
        else $error("levels changed between evaluations");
    a_evt_stamp: assert property (
        evt_valid_o && $past(evt_valid_o) |-> $stable(evt_time_o))
        else $error("events of one evaluation differ in stamp");
    a_ref_sel: assert property (
        freq_ref_sel_o != 2'h3)
        else $error("tracking reference out of range");
    a_evt_kind: assert property (
        evt_valid_o |-> evt_kind_o != 2'h3)
        else $error("event kind out of range");
endmodule // rocof_stages_checker

bind rocof_stages rocof_stages_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (.*);

// ### sim/rocof_front_model.sv
// Measurement front-end and blocking matrix model
`timescale 1ns/1ps
module rocof_front_model #(
    parameter int unsigned MS_CYCLES = 10
) (
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic [15:0] freq_set_i,
    input  wire logic [15:0] slope_set_i,
    input  wire logic [7:0]  block_set_i,
    output logic      [15:0] freq_o,
    output logic      [15:0] slope_o,
    output logic             meas_valid_o,
    output logic      [7:0]  block_o
);
    int cnt_q;
    // Millisecond sample strobe, several per 5 ms evaluation
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q <= 0;
        end else begin
            cnt_q <= (cnt_q == MS_CYCLES - 1) ? 0 : cnt_q + 1;
        end
    end
    assign meas_valid_o = reset_n_i && (cnt_q == MS_CYCLES - 1);
    // Measured values and blocking levels pass straight through
    assign freq_o  = freq_set_i;
    assign slope_o = slope_set_i;
    assign block_o = block_set_i; // set well ahead of any delay end
endmodule // rocof_front_model

// ### sim/tb_top.sv
// Self-checking bench for the slope protection stages
`timescale 1ns/1ps
`include "rocof_params.svh"
module tb_top;
    localparam int TK = 50;
    logic        mclk_i = 1'b0, reset_n_i = 1'b0;
    logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h000;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, evt_time_o;
    logic [15:0] fset = 16'h1388, sset = 16'h0000, freq_i, slope_i;
    logic [7:0]  bset = 8'h00, block_i, start_o, trip_o, blocked_o;
    logic [2:0]  sg_sel_i = 3'h0, evt_stage_o;
    logic [1:0]  freq_ref_sel_o, evt_kind_o;
    logic        meas_valid_i, evt_valid_o, evt_on_o;
    int          errors = 0, checks_done = 0, cycles = 0;
    rocof_front_model #(.MS_CYCLES(10)) u_front (.mclk_i(mclk_i),
        .reset_n_i(reset_n_i), .freq_set_i(fset), .slope_set_i(sset),
        .block_set_i(bset), .freq_o(freq_i), .slope_o(slope_i),
        .meas_valid_o(meas_valid_i), .block_o(block_i));
    rocof_stages #(.MS_CYCLES(10)) dut (.mclk_i(mclk_i),
        .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .freq_i(freq_i),
        .slope_i(slope_i), .meas_valid_i(meas_valid_i),
        .block_i(block_i), .sg_sel_i(sg_sel_i),
        .freq_ref_sel_o(freq_ref_sel_o), .start_o(start_o),
        .trip_o(trip_o), .blocked_o(blocked_o), .evt_valid_o(evt_valid_o),
        .evt_stage_o(evt_stage_o), .evt_kind_o(evt_kind_o),
        .evt_on_o(evt_on_o), .evt_time_o(evt_time_o));
    always #10 mclk_i = ~mclk_i;
    // ****************************************
    // Helpers
    // ****************************************
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge mclk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        @(posedge mclk_i);
        cmp(reg_rdata_o, e);
    endtask
    // Setting address of group 0, stage 0
    function automatic logic [11:0] sa(input logic [2:0] f);
        return 12'h800 | {7'h0, f, 2'h0};
    endfunction
    // Apply slope and block, let two evaluations pass, check stage 0
    task automatic st(input logic [15:0] s, input logic b,
                      input logic [2:0] e);
        sset <= s;
        bset <= {7'h0, b};
        repeat (2 * TK + 5) @(posedge mclk_i);
        cmp({29'h0, blocked_o[0], trip_o[0], start_o[0]}, {29'h0, e});
    endtask
    // Wait for the next event and check it belongs to stage 0
    task automatic ev(input logic [1:0] k, input logic on,
                      output logic [31:0] t);
        int n;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (evt_valid_o !== 1'b1 && n < 3 * TK);
        cmp({evt_valid_o, evt_stage_o, evt_kind_o, evt_on_o},
            {1'b1, 3'h0, k, on});
        t = evt_time_o;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic check_defaults();
        rd(`ROCOF_MAXRATE, 32'h0000_07d0);
        rd(`ROCOF_STEN, 32'h0000_5555);
        rd(sa(`ROCOF_SET_CFG), 32'h0);
        rd(sa(`ROCOF_SET_PICK), 32'h0000_0014);
        rd(sa(`ROCOF_SET_FUF), 32'h0000_1383);
        rd(sa(`ROCOF_SET_FOF), 32'h0000_13ec);
        rd(sa(`ROCOF_SET_DLY), 32'h0000_0014);
        rd(12'hffc, 32'h0);
        rd(`ROCOF_TIME, 32'h0000_0002);
        st(16'h001e, 1'b0, 3'b000);
    endtask
    task automatic instant_trip();
        logic [31:0] ta, tb, tc;
        wr(`ROCOF_STEN, 32'h0000_5556);
        wr(sa(`ROCOF_SET_CFG), 32'h1);
        wr(sa(`ROCOF_SET_DLY), 32'h0);
        sset <= 16'h001e;
        ev(2'h0, 1'b1, ta);
        ev(2'h1, 1'b1, tb);
        cmp(ta, tb);
        st(16'h000b, 1'b0, 3'b011);
        rd(`ROCOF_STATUS, 32'h0000_0101);
        sset <= 16'h000a;
        ev(2'h0, 1'b0, tc);
        cmp((tc - ta) % 5, 32'h0);
        ev(2'h1, 1'b0, tc);
    endtask
    task automatic block_stage();
        logic [31:0] t;
        bset <= 8'h01;
        sset <= 16'h001e;
        ev(2'h2, 1'b1, t);
        st(16'h001e, 1'b1, 3'b100);
        st(16'h001e, 1'b0, 3'b011);
        st(16'h0834, 1'b0, 3'b100);
        st(16'h07d0, 1'b0, 3'b011);
    endtask
    task automatic counters_ratio();
        rd(12'h100, 32'h3);
        rd(12'h104, 32'h3);
        rd(12'h108, 32'h2);
        wr(`ROCOF_CTRL, 32'h8);
        rd(12'h100, 32'h0);
        rd(`ROCOF_CTRL, 32'h0);
        rd(12'h200, 32'h0000_4e20);
        st(16'h001e, 1'b0, 3'b011);
        rd(12'h200, 32'h0000_05dc);
    endtask
    task automatic dir_gate();
        st(16'hffe2, 1'b0, 3'b000);
        wr(sa(`ROCOF_SET_CFG), 32'h3);
        st(16'hffe2, 1'b0, 3'b011);
        wr(sa(`ROCOF_SET_CFG), 32'hd);
        st(16'hffe2, 1'b0, 3'b000);
        fset <= 16'h1382;
        st(16'hffe2, 1'b0, 3'b011);
        st(16'h001e, 1'b0, 3'b000);
        fset <= 16'h13ed;
        st(16'h001e, 1'b0, 3'b011);
    endtask
    task automatic delay_trip();
        int n;
        wr(sa(`ROCOF_SET_CFG), 32'h1);
        wr(sa(`ROCOF_SET_DLY), 32'h2);
        st(16'h0000, 1'b0, 3'b000);
        sset <= 16'h001e;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (start_o[0] !== 1'b1 && n < 3 * TK);
        repeat (TK + 10) @(posedge mclk_i);
        cmp({31'h0, trip_o[0]}, 32'h0);
        repeat (TK) @(posedge mclk_i);
        cmp({31'h0, trip_o[0]}, 32'h1);
    endtask
    task automatic group_force();
        sg_sel_i <= 3'h1;
        st(16'h001e, 1'b0, 3'b000);
        sg_sel_i <= 3'h0;
        wr(`ROCOF_FORCE, 32'h3);
        st(16'h0000, 1'b0, 3'b000);
        wr(`ROCOF_CTRL, 32'h5);
        st(16'h0000, 1'b0, 3'b100);
        rd(`ROCOF_CTRL, 32'h5);
        cmp({30'h0, freq_ref_sel_o}, 32'h1);
        wr(`ROCOF_CTRL, 32'h7);
        rd(`ROCOF_CTRL, 32'h5);
        wr(`ROCOF_FORCE, 32'h2);
        st(16'h0000, 1'b0, 3'b011);
        wr(`ROCOF_FORCE, 32'h1);
        st(16'h0000, 1'b0, 3'b001);
        wr(`ROCOF_CTRL, 32'h0);
        st(16'h0000, 1'b0, 3'b000);
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        check_defaults();
        instant_trip();
        block_stage();
        counters_ratio();
        dir_gate();
        delay_trip();
        group_force();
        summarize();
    end
endmodule // tb_top
